// *** core/see_dev.sv ***
`timescale 1ns/100ps
`default_nettype none
module see_dev
  import see_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic select_pin_bit0,
  input wire logic select_pin_bit1,
  input wire logic select_pin_bit2,
  input wire logic write_protect,
  output logic busy,
  see_link_if.dev link
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // ==========================================================
  // Declarations
  see_dev_st_t st_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic ack_reg;
  logic wr_pend_reg;
  logic wp_reg;
  logic oe_reg;
  logic start_reg;
  logic stop_reg;
  logic start_clr_reg;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [7:0] pbuf_reg [PAGE_BYTES];
  logic [7:0] mem_reg [MEM_BYTES];
  logic busy_reg;
  logic [CNT_W-1:0] prog_cnt_reg;
  logic stop_d_reg;
  logic busy_l;
  logic [1:0] evt_s;
  logic [7:0] rx;
  logic [7:0] rd_byte;
  logic [2:0] sel;
  logic byte_end;
  logic pb_we;
  logic commit;
  logic start_rst;
  logic stop_rst;
  logic sel_hit;

  assign sel = {select_pin_bit2, select_pin_bit1, select_pin_bit0};
  assign rx = {sh_reg[6:0], link.sda};
  assign rd_byte = mem_reg[addr_reg];
  assign byte_end = ~start_reg & (bit_reg == LAST_BIT);
  assign sel_hit = (rx[7:4] == DEV_TYPE) & (rx[3:1] == sel);
  assign pb_we = byte_end & (st_reg == DS_WDATA) & ~wp_reg;
  assign link.d_sda_o = 1'h0;
  assign link.d_sda_oe = oe_reg;
  assign busy = busy_reg;

  // ==========================================================
  // Bus condition detection
  // The link clock stops between frames, so these flags are
  // cleared asynchronously instead of waiting for an edge.
  assign start_rst = start_clr_reg | ~rstn;
  assign stop_rst = start_reg | ~rstn;

  always_ff @(negedge link.sda or posedge start_rst) begin
    if (start_rst) begin
      start_reg <= 1'h0;
    end else if (link.scl) begin
      start_reg <= 1'h1;
    end
  end

  always_ff @(posedge link.sda or posedge stop_rst) begin
    if (stop_rst) begin
      stop_reg <= 1'h0;
    end else if (link.scl) begin
      stop_reg <= 1'h1;
    end
  end

  // ==========================================================
  // Crossings
  see_sync #(.W(1)) u_busy_sync (
    .clk(link.scl),
    .d(busy_reg),
    .q(busy_l)
  );

  // Page buffer and address are quiet once STOP is seen
  see_sync #(.W(2)) u_evt_sync (
    .clk(mclk),
    .d({stop_reg, wr_pend_reg}),
    .q(evt_s)
  );

  // ==========================================================
  // Receive and transmit engine, rising edge
  // sample on rise
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      st_reg <= DS_IDLE;
      bit_reg <= '0;
      sh_reg <= '0;
      tx_reg <= '0;
      addr_reg <= '0;
      ack_reg <= 1'h0;
      wr_pend_reg <= 1'h0;
      mask_reg <= '0;
      start_clr_reg <= 1'h0;
    end else if (start_reg) begin
      // First address bit arrives on this same edge
      st_reg <= DS_DEVADR;
      bit_reg <= 4'h1;
      sh_reg <= {7'h00, link.sda};
      ack_reg <= 1'h0;
      wr_pend_reg <= 1'h0;
      mask_reg <= '0;
      start_clr_reg <= 1'h1;
    end else begin
      start_clr_reg <= 1'h0;
      if (bit_reg == ACK_BIT) begin
        bit_reg <= '0;
        case (st_reg)
          DS_RACK: begin
            st_reg <= DS_RDATA;
            tx_reg <= rd_byte;
            addr_reg <= addr_reg + 12'h001;
          end
          DS_RDATA: begin
            if (link.sda) begin
              st_reg <= DS_IDLE;
            end else begin
              tx_reg <= rd_byte;
              addr_reg <= addr_reg + 12'h001;
            end
          end
          default: begin
          end
        endcase
      end else begin
        bit_reg <= bit_reg + 4'h1;
        sh_reg <= rx;
        if (bit_reg == LAST_BIT) begin
          ack_reg <= 1'h1;
          case (st_reg)
            DS_DEVADR: begin
              if (sel_hit && !busy_l) begin
                st_reg <= rx[0] ? DS_RACK : DS_ADRH;
              end else begin
                ack_reg <= 1'h0;
                st_reg <= DS_IDLE;
              end
            end
            DS_ADRH: begin
              addr_reg[11:8] <= rx[3:0];
              st_reg <= DS_ADRL;
            end
            DS_ADRL: begin
              addr_reg[7:0] <= rx;
              st_reg <= DS_WDATA;
            end
            DS_WDATA: begin
              if (wp_reg) begin
                ack_reg <= 1'h0;
                st_reg <= DS_IDLE;
                wr_pend_reg <= 1'h0;
                mask_reg <= '0;
              end else begin
                mask_reg[addr_reg[4:0]] <= 1'h1;
                addr_reg[4:0] <= addr_reg[4:0] + 5'h01;
                wr_pend_reg <= 1'h1;
              end
            end
            default: begin
              ack_reg <= 1'h0;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Page buffer
  for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_pbuf
    always_ff @(posedge link.scl) begin
      if (pb_we && (addr_reg[4:0] == PAGE_W'(g))) begin
        pbuf_reg[g] <= rx;
      end
    end
  end

  // ==========================================================
  // Data line drive, falling edge
  always_ff @(negedge link.scl or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= 1'h0;
    end else if (st_reg == DS_WDATA && bit_reg == 4'h0 && !wr_pend_reg) begin
      wp_reg <= write_protect;
    end
  end

  always_ff @(negedge link.scl or negedge rstn) begin
    if (!rstn) begin
      oe_reg <= 1'h0;
    end else if (start_reg) begin
      oe_reg <= 1'h0;
    end else if (bit_reg == ACK_BIT) begin
      oe_reg <= ack_reg;
    end else if (st_reg == DS_RDATA) begin
      oe_reg <= ~tx_reg[3'h7 - bit_reg[2:0]];
    end else begin
      oe_reg <= 1'h0;
    end
  end

  // ==========================================================
  // Programming cycle, system clock
  // STOP after buffered write data starts programming
  assign commit = evt_s[1] & ~stop_d_reg & evt_s[0];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stop_d_reg <= 1'h0;
    end else begin
      stop_d_reg <= evt_s[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy_reg <= 1'h0;
      prog_cnt_reg <= '0;
    end else if (commit) begin
      busy_reg <= 1'h1;
      prog_cnt_reg <= CNT_W'(PROG_CYCLES - 1);
    end else if (busy_reg) begin
      if (prog_cnt_reg == '0) begin
        busy_reg <= 1'h0;
      end else begin
        prog_cnt_reg <= prog_cnt_reg - 1'h1;
      end
    end
  end

  // Whole array rewritten on reset; costly but models delivery
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_reg[i] <= ERASED;
      end
    end else if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_reg[i]) begin
          mem_reg[{addr_reg[11:5], PAGE_W'(i)}] <= pbuf_reg[i];
        end
      end
    end
  end
endmodule // see_dev
`default_nettype wire

// *** core/see_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module see_host
  import see_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] dev_sel,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_rd,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_err,
  see_link_if.host link
);
  localparam int QW = $clog2(QTR_CYC);

  see_host_st_t st_reg;
  logic [QW-1:0] q_reg;
  logic [1:0] ph_reg;
  logic [2:0] idx_reg;
  logic [3:0] bit_reg;
  logic [7:0] rx_reg;
  logic [7:0] rdata_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] wdata_reg;
  logic rd_reg;
  logic scl_reg;
  logic oe_reg;
  logic nack_reg;
  logic retry_reg;
  logic err_reg;
  logic rsp_reg;
  logic sda_s;
  logic tick;
  logic last_wr;
  logic [7:0] cur_byte;
  logic [7:0] nxt_byte;

  // Byte sent at each step; the read data step releases the line
  function automatic logic [7:0] tx_byte(input logic [2:0] i);
    case (i)
      3'h0: tx_byte = {DEV_TYPE, dev_sel, 1'h0};
      3'h1: tx_byte = {4'h0, addr_reg[11:8]};
      IDX_ADRL: tx_byte = addr_reg[7:0];
      IDX_DATA: tx_byte = rd_reg ? {DEV_TYPE, dev_sel, 1'h1} : wdata_reg;
      default: tx_byte = 8'hff;
    endcase
  endfunction

  see_sync #(.W(1)) u_sda_sync (
    .clk(mclk),
    .d(link.sda),
    .q(sda_s)
  );

  assign cur_byte = tx_byte(idx_reg);
  assign nxt_byte = tx_byte(idx_reg + 3'h1);
  assign tick = (q_reg == QW'(QTR_CYC - 1));
  assign last_wr = (idx_reg == IDX_DATA) & ~rd_reg;
  assign req_ready = (st_reg == HS_IDLE);
  assign link.scl = scl_reg;
  assign link.h_sda_o = 1'h0;
  assign link.h_sda_oe = oe_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign rsp_err = err_reg;

  // ==========================================================
  // Quarter-period divider for the serial clock
  always_ff @(posedge mclk) begin
    if (!rstn || st_reg == HS_IDLE || tick) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_reg + 1'h1;
    end
  end

  // ==========================================================
  // Bit sequencer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg <= HS_IDLE;
      ph_reg <= 2'h0;
      idx_reg <= 3'h0;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      rdata_reg <= 8'h00;
      addr_reg <= '0;
      wdata_reg <= 8'h00;
      rd_reg <= 1'h0;
      scl_reg <= 1'h1;
      oe_reg <= 1'h0;
      nack_reg <= 1'h0;
      retry_reg <= 1'h0;
      err_reg <= 1'h0;
      rsp_reg <= 1'h0;
    end else begin
      rsp_reg <= 1'h0;
      if (st_reg != HS_IDLE && tick) begin
        ph_reg <= ph_reg + 2'h1;
      end
      case (st_reg)
        HS_IDLE: begin
          ph_reg <= 2'h0;
          if (req_valid) begin
            st_reg <= HS_START;
            idx_reg <= 3'h0;
            rd_reg <= req_rd;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
            err_reg <= 1'h0;
          end
        end
        HS_START: begin
          if (tick) begin
            case (ph_reg)
              2'h0: scl_reg <= 1'h1;
              2'h1: oe_reg <= 1'h1;
              2'h2: scl_reg <= 1'h0;
              default: begin
                oe_reg <= ~cur_byte[7];
                bit_reg <= 4'h0;
                st_reg <= HS_BIT;
              end
            endcase
          end
        end
        HS_BIT: begin
          if (tick) begin
            case (ph_reg)
              2'h0: scl_reg <= 1'h1;
              2'h1: begin
                if (bit_reg == ACK_BIT) begin
                  nack_reg <= sda_s;
                end else begin
                  rx_reg <= {rx_reg[6:0], sda_s};
                end
              end
              2'h2: scl_reg <= 1'h0;
              default: begin
                if (bit_reg != ACK_BIT) begin
                  bit_reg <= bit_reg + 4'h1;
                  oe_reg <= (bit_reg == LAST_BIT) ? 1'h0 : ~cur_byte[3'h6 - bit_reg[2:0]];
                end else if (idx_reg == IDX_RDATA) begin
                  st_reg <= HS_STOP;
                  oe_reg <= 1'h1;
                  retry_reg <= 1'h0;
                end else if (nack_reg) begin
                  st_reg <= HS_STOP;
                  oe_reg <= 1'h1;
                  retry_reg <= ~last_wr;
                  err_reg <= last_wr;
                end else if (last_wr) begin
                  st_reg <= HS_STOP;
                  oe_reg <= 1'h1;
                  retry_reg <= 1'h0;
                end else if (idx_reg == IDX_ADRL && rd_reg) begin
                  idx_reg <= IDX_DATA;
                  oe_reg <= 1'h0;
                  st_reg <= HS_START;
                end else begin
                  idx_reg <= idx_reg + 3'h1;
                  bit_reg <= 4'h0;
                  oe_reg <= ~nxt_byte[7];
                end
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            case (ph_reg)
              2'h0: scl_reg <= 1'h1;
              2'h1: oe_reg <= 1'h0;
              2'h3: begin
                if (retry_reg) begin
                  st_reg <= HS_START;
                  idx_reg <= 3'h0;
                end else begin
                  st_reg <= HS_IDLE;
                  rsp_reg <= 1'h1;
                  rdata_reg <= rx_reg;
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end
endmodule // see_host
`default_nettype wire

// *** core/see_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface see_link_if;
  logic scl;
  logic sda;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  // Open drain with pull-up: any enabled low wins
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
  modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
endinterface
`default_nettype wire

// *** core/see_pkg.sv ***
// Contract
// - Master byte write: S, write address, two bytes, data, P
// - Device acks every byte written to it; protected write data, and the device address while busy, get NoACK
// - STOP starts programming; device silent while busy
// - Page buffer takes up to 32 bytes
// - Page latched; offset increments and wraps in page
// - Whole page programmed in one cycle; only bytes loaded into the page buffer are written
// - Master retries request after each NoACK; a NoACK of write data is not retried but ends with an error
// - Write protect high blocks all writes
// - Write protect strobed on falling edge before data
// - Protected write: data NoACK, request discarded
// - Array starts erased, every byte all ones
// - Read address: ack, send current byte MSB first
// - Master NoACK then STOP ends read; device idles
// - Addressed read: write address, repeated START, read
// - Addressed read returns byte at loaded address
// - Master ACK requests next byte
// - Read address increments, wraps to zero
// - Respond only to matching type and select bits
// - Sample on rising clock, change on falling
// - START and STOP detected while clock high
package see_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Serial clock period; a quarter must outlast the two-flop data synchroniser
  localparam int SCL_PERIOD_NS = 1000;
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYC = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ADDR_W = 12;
  localparam int MEM_BYTES = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam logic [7:0] ERASED = 8'hff;
  // Device type code; the value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [2:0] IDX_ADRL = 3'h2;
  localparam logic [2:0] IDX_DATA = 3'h3;
  localparam logic [2:0] IDX_RDATA = 3'h4;
  typedef enum logic [2:0] {
    DS_IDLE, DS_DEVADR, DS_ADRH, DS_ADRL, DS_WDATA, DS_RACK, DS_RDATA
  } see_dev_st_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} see_host_st_t;
endpackage

// *** core/see_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module see_sync
  import see_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg <= meta_reg;
  end
  assign q = q_reg;
endmodule // see_sync
`default_nettype wire

// *** test/see_link_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module see_link_assertions #(
  parameter int PROG_CYCLES = 5000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic busy,
  input wire logic scl,
  input wire logic sda,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe
);
  // ==========================================
  // Busy window length
  // ==========================================
  int busy_cnt_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy_cnt_reg <= 0;
    end else if (busy) begin
      busy_cnt_reg <= busy_cnt_reg + 1;
    end else begin
      busy_cnt_reg <= 0;
    end
  end

  // ==========================================
  // Properties
  // ==========================================
  // Sampled on the system clock so scl edges are seen as level changes
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  a_ack_rise_low: assert property ($rose(d_sda_oe) |-> !scl)
    else $error("device drive started while clock high");
  a_ack_fall_low: assert property ($fell(d_sda_oe) |-> !scl)
    else $error("device drive ended while clock high");
  a_oe_hold_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device drive changed during clock high");
  a_busy_silent: assert property (busy |-> !d_sda_oe)
    else $error("device drives data line while programming");
  a_busy_length: assert property ($fell(busy) |-> busy_cnt_reg == PROG_CYCLES)
    else $error("programming window has wrong length");
  a_stop_release: assert property (scl && $past(scl) && $rose(sda) |=> !d_sda_oe [*8])
    else $error("device drives data line after stop");
  a_busy_after_stop: assert property ($rose(busy) |-> scl && sda && !h_sda_oe)
    else $error("programming started without a stop on an idle bus");
  a_open_drain: assert property (!d_sda_o && !h_sda_o)
    else $error("data line driven high");
endmodule // see_link_assertions
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import see_pkg::*;
;
  // Long enough that a read issued right after a write is refused and retried
  localparam int PROG_N = 5000;
  logic mclk = 1'b0;
  logic rstn = 1'b1;
  logic [2:0] sel_reg = 3'h5;
  logic [2:0] dev_sel = 3'h5;
  logic write_protect = 1'b0;
  logic req_valid = 1'b0;
  logic req_rd = 1'b0;
  logic [ADDR_W-1:0] req_addr = 12'h000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready;
  logic rsp_valid;
  logic rsp_err;
  logic busy;
  logic [7:0] rsp_rdata;
  logic [7:0] got;
  logic got_err;
  logic got_busy;
  logic hit;
  int err_total = 0;
  int n_compared = 0;

  see_link_if link();
  see_dev #(.PROG_CYCLES(PROG_N)) u_see_dev (
    .mclk(mclk),
    .rstn(rstn),
    .select_pin_bit0(sel_reg[0]),
    .select_pin_bit1(sel_reg[1]),
    .select_pin_bit2(sel_reg[2]),
    .write_protect(write_protect),
    .busy(busy),
    .link(link.dev)
  );
  see_host u_see_host (
    .mclk(mclk),
    .rstn(rstn),
    .dev_sel(dev_sel),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_rd(req_rd),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .rsp_err(rsp_err),
    .link(link.host)
  );
  see_link_assertions #(.PROG_CYCLES(PROG_N)) u_see_link_assertions (
    .mclk(mclk),
    .rstn(rstn),
    .busy(busy),
    .scl(link.scl),
    .sda(link.sda),
    .h_sda_o(link.h_sda_o),
    .h_sda_oe(link.h_sda_oe),
    .d_sda_o(link.d_sda_o),
    .d_sda_oe(link.d_sda_oe)
  );

  initial begin
    forever #4 mclk = ~mclk;
  end

  // ==========================================
  // Checking and closing
  // ==========================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // Host request protocol
  // ==========================================
  task automatic issue(input logic rd, input logic [ADDR_W-1:0] addr, input logic [7:0] wd);
    int n;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_rd <= rd;
    req_addr <= addr;
    req_wdata <= wd;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (req_ready !== 1'b1) begin
      check(8'h00, 8'h01);
      end_of_test();
    end
    // Taken at this edge; valid drops by the same edge's update
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask

  task automatic access(input logic rd, input logic [ADDR_W-1:0] addr, input logic [7:0] wd);
    int n;
    issue(rd, addr, wd);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 40000);
    if (rsp_valid !== 1'b1) begin
      check(8'h00, 8'h01);
      end_of_test();
    end
    got = rsp_rdata;
    got_err = rsp_err;
    got_busy = busy;
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  initial begin
    // A real falling edge is needed so the link-side flops reset
    rstn <= 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    access(1'b1, 12'h123, 8'h00);
    check(got, ERASED);
    access(1'b0, 12'h123, 8'ha5);
    check({7'h00, got_err}, 8'h00);
    check({7'h00, got_busy}, 8'h01);
    // Read lands inside the programming window and must be retried
    access(1'b1, 12'h123, 8'h00);
    check(got, 8'ha5);
    check({7'h00, got_busy}, 8'h00);
    access(1'b0, 12'hfff, 8'h3c);
    access(1'b1, 12'hfff, 8'h00);
    check(got, 8'h3c);
    access(1'b1, 12'h122, 8'h00);
    check(got, ERASED);
    @(posedge mclk);
    write_protect <= 1'b1;
    access(1'b0, 12'h010, 8'h77);
    check({7'h00, got_err}, 8'h01);
    check({7'h00, got_busy}, 8'h00);
    @(posedge mclk);
    write_protect <= 1'b0;
    access(1'b1, 12'h010, 8'h00);
    check(got, ERASED);
    access(1'b0, 12'h010, 8'h5a);
    check({7'h00, got_err}, 8'h00);
    access(1'b1, 12'h010, 8'h00);
    check(got, 8'h5a);
    // Wrong select bits: host keeps polling, so only a reset frees it
    @(posedge mclk);
    dev_sel <= 3'h2;
    issue(1'b1, 12'h010, 8'h00);
    hit = 1'b0;
    repeat (6000) begin
      @(posedge mclk);
      #1;
      hit = hit | rsp_valid | link.d_sda_oe;
    end
    check({7'h00, hit}, 8'h00);
    @(posedge mclk);
    rstn <= 1'b0;
    sel_reg <= 3'h2;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    access(1'b1, 12'h010, 8'h00);
    check(got, ERASED);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
